// ### hw/sar_adc_pkg.sv
// Shared constants for the successive-approximation converter control
package sar_adc_pkg;
   localparam int          RES_BITS        = 8;
   localparam logic [7:0]  CODE_FULL       = 8'hFF;
   localparam logic [7:0]  CODE_ZERO       = 8'h00;
   localparam logic [7:0]  CTRL_RESET      = 8'h40;
   localparam int          IRQ_EN_POS      = 7;
   localparam int          EOC_POS         = 6;
   localparam int          START_POS       = 5;
   localparam int          POWER_POS       = 4;
   localparam int          OSC_POS         = 2;
   localparam int          CONV_TIME_NS    = 70000;
   localparam int          CLK_PERIOD_NS   = 5;
   localparam int          CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int          STEP_CYCLES     = CONV_CYCLES / RES_BITS;
endpackage : sar_adc_pkg

// ### hw/sar_step_timer.sv
// Step timer pacing one approximation bit per period
`timescale 1ns/1ps
module sar_step_timer #(
   parameter int STEP = sar_adc_pkg::STEP_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic restart_i,
   input  wire logic run_i,
   output logic      tick_o
);
   localparam int W = $clog2(STEP + 1);
   localparam logic [W-1:0] LAST = W'(STEP - 1);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic         next_tick;

   // Count up one step, restart on demand
   always_comb begin
      next_count = count;
      next_tick  = 1'b0;
      if (restart_i || !run_i) begin
         next_count = '0;
      end else if (count == LAST) begin
         next_count = '0;
         next_tick  = 1'b1;
      end else begin
         next_count = count + W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count  <= '0;
         tick_o <= 1'b0;
      end else begin
         count  <= next_count;
         tick_o <= next_tick;
      end
   end
endmodule : sar_step_timer

// ### hw/comp_sync.sv
// Two-stage synchroniser for the analog comparator output
`timescale 1ns/1ps
module comp_sync (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta;

   // First stage feeds only the second
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta   <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule : comp_sync

// ### hw/sar_adc_conversion_control.sv
// Conversion control of an 8-bit successive-approximation converter
// Operation
// - Binary search gives 8-bit code, stored
// - Input above range yields FF, no overflow
// - Input below range yields 00
// - Start write begins conversion, clears flag
// - Finished conversion sets end flag
// - Completion with enable raises interrupt request
// - Start during conversion restarts it
// - Start bit reads back as zero
// - One conversion per start write
// - Power bit switches converter on/off
// - Wait mode runs; interrupt wakes device
// - Flag cleared only by a start
// - Conversion takes nine steps, about 79 microseconds
// - Control reads 40h after reset
`timescale 1ns/1ps
module sar_adc_conversion_control #(
   parameter int CONV_CYCLES = sar_adc_pkg::CONV_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       ctrl_wr_i,
   input  wire logic [7:0] ctrl_wdata_i,
   input  wire logic       stop_mode_i,
   input  wire logic       comp_i,
   output logic [7:0]      conv_control_reg_o,
   output logic [7:0]      result_register_o,
   output logic [7:0]      dac_code_o,
   output logic            analog_enable_o,
   output logic            conv_irq_o,
   output logic            wake_o,
   output logic            busy_o
);
   // Step length scales the whole conversion with the clock
   localparam int STEP = CONV_CYCLES / sar_adc_pkg::RES_BITS;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b001,
      S_SETTLE = 3'b010,
      S_CONV   = 3'b100
   } conv_state_e;

   conv_state_e state;
   conv_state_e next_state;
   logic        conv_irq_enable;
   logic        conv_power_on;
   logic        osc_off;
   logic        eoc;
   logic [7:0]  trial;
   logic [7:0]  result;
   logic [2:0]  bit_idx;
   logic        next_irq_enable;
   logic        next_power_on;
   logic        next_osc_off;
   logic        next_eoc;
   logic [7:0]  next_trial;
   logic [7:0]  next_result;
   logic [2:0]  next_bit_idx;
   logic        comp_sync;
   logic        tick;
   logic        start_req;
   logic        powered;
   logic        restart;

   comp_sync u_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  (comp_i),
      .sync_o   (comp_sync)
   );

   sar_step_timer #(.STEP(STEP)) u_timer (
      .clk_i     (clk_i),
      .resetn_i  (resetn_i),
      .restart_i (restart),
      .run_i     (state != S_IDLE),
      .tick_o    (tick)
   );

   // Start strobe and power gating
   assign start_req = ctrl_wr_i && ctrl_wdata_i[sar_adc_pkg::START_POS];
   assign powered   = conv_power_on && !stop_mode_i;
   assign restart   = start_req || !powered;

   // Control bits and conversion sequence
   always_comb begin
      next_state      = state;
      next_irq_enable = conv_irq_enable;
      next_power_on   = conv_power_on;
      next_osc_off    = osc_off;
      next_eoc        = eoc;
      next_trial      = trial;
      next_result     = result;
      next_bit_idx    = bit_idx;
      if (ctrl_wr_i) begin
         next_irq_enable = ctrl_wdata_i[sar_adc_pkg::IRQ_EN_POS];
         next_power_on   = ctrl_wdata_i[sar_adc_pkg::POWER_POS];
         next_osc_off    = ctrl_wdata_i[sar_adc_pkg::OSC_POS];
      end
      case (state)
         S_IDLE: begin
            if (start_req && powered) begin
               next_state = S_SETTLE;
            end
         end
         S_SETTLE: begin
            // One step of sampling before the first trial
            if (tick) begin
               next_state   = S_CONV;
               next_bit_idx = 3'd7;
               next_trial   = 8'h80;
            end
         end
         S_CONV: begin
            if (tick) begin
               // Keep trial bit when input exceeds trial level
               if (!comp_sync) begin
                  next_trial[bit_idx] = 1'b0;
               end
               if (bit_idx == 3'd0) begin
                  next_result = comp_sync ? trial : (trial & ~8'h01);
                  next_eoc    = 1'b1;
                  next_state  = S_IDLE;
               end else begin
                  next_trial[bit_idx - 3'd1] = 1'b1;
                  next_bit_idx = bit_idx - 3'd1;
               end
            end
         end
         default: next_state = S_IDLE;
      endcase
      // Restart or abandon overrides the next state; a start also clears flag and trial
      if (start_req) begin
         next_eoc   = 1'b0;
         next_trial = 8'h00;
         next_state = powered ? S_SETTLE : S_IDLE;
      end else if (!powered) begin
         next_state = S_IDLE;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state           <= S_IDLE;
         conv_irq_enable <= 1'b0;
         conv_power_on   <= 1'b0;
         osc_off         <= 1'b0;
         eoc             <= 1'b1;
         trial           <= 8'h00;
         result          <= 8'h00;
         bit_idx         <= 3'd7;
      end else begin
         state           <= next_state;
         conv_irq_enable <= next_irq_enable;
         conv_power_on   <= next_power_on;
         osc_off         <= next_osc_off;
         eoc             <= next_eoc;
         trial           <= next_trial;
         result          <= next_result;
         bit_idx         <= next_bit_idx;
      end
   end

   // Registered outputs
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         conv_control_reg_o <= sar_adc_pkg::CTRL_RESET;
         result_register_o  <= 8'h00;
         dac_code_o         <= 8'h00;
         analog_enable_o    <= 1'b0;
         conv_irq_o         <= 1'b0;
         wake_o             <= 1'b0;
         busy_o             <= 1'b0;
      end else begin
         // Start position always reads zero
         conv_control_reg_o <= {next_irq_enable, next_eoc, 1'b0, next_power_on,
                                1'b0, next_osc_off, 2'b00};
         result_register_o  <= next_result;
         dac_code_o         <= next_trial;
         analog_enable_o    <= next_power_on && !stop_mode_i;
         conv_irq_o         <= next_eoc && next_irq_enable;
         wake_o             <= next_eoc && next_irq_enable && !stop_mode_i;
         busy_o             <= next_state != S_IDLE;
      end
   end

   // Checks
   sequence start_seq;
      ctrl_wr_i && ctrl_wdata_i[sar_adc_pkg::START_POS];
   endsequence

   start_clears_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_seq |=> !conv_control_reg_o[sar_adc_pkg::EOC_POS])
      else $error("start did not clear end flag");
   start_bit_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !conv_control_reg_o[sar_adc_pkg::START_POS])
      else $error("start bit read as one");
   irq_follows_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      conv_irq_o == (conv_control_reg_o[7] && conv_control_reg_o[6]))
      else $error("interrupt not tied to flag and enable");
   eoc_sticky_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      eoc && !start_req |=> eoc)
      else $error("end flag cleared without start");
   done_sets_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      state == S_CONV && tick && bit_idx == 3'd0 && !start_req && powered
      |=> eoc && state == S_IDLE)
      else $error("finish did not set flag");
   restart_conv_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_req && powered |=> state == S_SETTLE)
      else $error("start did not restart");
   power_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !powered |=> state == S_IDLE)
      else $error("runs while switched off");
   stop_nowake_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      stop_mode_i && $past(stop_mode_i) |-> !wake_o)
      else $error("wake in stop mode");
   one_shot_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      state == S_IDLE && !start_req |=> state == S_IDLE)
      else $error("conversion without start");

   // Pieces of the final approximation step
   sequence last_step_seq;
      state == S_CONV && tick && bit_idx == 3'd0;
   endsequence

   sequence quiet_seq;
      !start_req && powered;
   endsequence

   // Top of range must end at full scale
   result_full_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      last_step_seq ##0 quiet_seq ##0 (trial == 8'hFF && comp_sync)
      |=> result_register_o == sar_adc_pkg::CODE_FULL)
      else $error("full scale code lost");

   // Bottom of range must end at zero
   result_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      last_step_seq ##0 quiet_seq ##0 (trial == 8'h01 && !comp_sync)
      |=> result_register_o == sar_adc_pkg::CODE_ZERO)
      else $error("zero code lost");

   // A low comparator drops the bit under trial
   trial_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      state == S_CONV && tick && !comp_sync && !start_req && powered
      |=> !dac_code_o[$past(bit_idx)])
      else $error("trial bit kept on low compare");

   // Busy flag mirrors the sequencer
   busy_tracks_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      busy_o == (state != S_IDLE))
      else $error("busy out of step");

   // Interrupt outside stop always wakes
   wake_in_wait_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      conv_irq_o && !$past(stop_mode_i) |-> wake_o)
      else $error("interrupt did not wake");

   // Analog enable follows the power bit, forced off in stop mode
   power_pin_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      analog_enable_o == (conv_control_reg_o[sar_adc_pkg::POWER_POS]
                          && !$past(stop_mode_i)))
      else $error("analog enable wrong");

   // Power bit changes only by a write
   power_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !ctrl_wr_i |=> $stable(conv_control_reg_o[sar_adc_pkg::POWER_POS]))
      else $error("power bit moved without write");

   // Cycle count of the running conversion, for the timing checks
   localparam int CONV_LIMIT = 9 * STEP + 4;
   localparam int CONV_FLOOR = 8 * STEP;
   logic [19:0] conv_len;
   logic [19:0] next_conv_len;

   // Count while converting, clear on idle or restart
   always_comb begin
      next_conv_len = 20'h00000;
      if (state != S_IDLE && !restart) begin
         next_conv_len = conv_len + 20'h00001;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         conv_len <= 20'h00000;
      end else begin
         conv_len <= next_conv_len;
      end
   end

   // Conversion never runs past its budget
   conv_time_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      int'(conv_len) <= CONV_LIMIT)
      else $error("conversion too long");

   // Conversion never finishes early
   conv_floor_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      last_step_seq ##0 quiet_seq |-> int'(conv_len) >= CONV_FLOOR)
      else $error("conversion too short");
endmodule : sar_adc_conversion_control

// ### test/sar_analog_source.sv
// Analog source and comparator model on the one selected input pin
`timescale 1ns/1ps
module sar_analog_source (
   input  wire logic       clk_i,
   input  wire logic       enable_i,
   input  wire logic [7:0] level_i,
   input  wire logic [7:0] dac_code_i,
   output logic            comp_o
);
   initial comp_o = 1'b0;
   // Compare pin voltage against trial code; unpowered front end wanders
   always @(posedge clk_i) begin
      if (enable_i) begin
         comp_o <= (level_i >= dac_code_i);
      end else begin
         comp_o <= ~comp_o;
      end
   end
endmodule : sar_analog_source

// ### test/sar_adc_conversion_control_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_conversion_control_tb;
   localparam int CONV = 80;
   logic       clk_i = 1'b0;
   logic       resetn_i = 1'b0;
   logic       ctrl_wr_i = 1'b0;
   logic [7:0] ctrl_wdata_i = 8'h00;
   logic       stop_mode_i = 1'b0;
   logic [7:0] level = 8'h00;
   logic       comp;
   logic [7:0] ctrl, result, dac;
   logic       aen, irq, wake, busy;
   int         bad_count = 0;
   int         checks = 0;
   int         n;
   logic [7:0] lv [4] = '{8'h5A, 8'hFF, 8'h00, 8'h81};

   sar_adc_conversion_control #(.CONV_CYCLES(CONV)) u_sar_adc_conversion_control (
      .clk_i(clk_i), .resetn_i(resetn_i), .ctrl_wr_i(ctrl_wr_i),
      .ctrl_wdata_i(ctrl_wdata_i), .stop_mode_i(stop_mode_i), .comp_i(comp),
      .conv_control_reg_o(ctrl), .result_register_o(result), .dac_code_o(dac),
      .analog_enable_o(aen), .conv_irq_o(irq), .wake_o(wake), .busy_o(busy));

   sar_analog_source u_sar_analog_source (
      .clk_i(clk_i), .enable_i(aen), .level_i(level), .dac_code_i(dac), .comp_o(comp));

   // Clock at 200 MHz
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask : chk1

   // One control write, launched and released on falling edges
   task automatic wr(input logic [7:0] d);
      ctrl_wr_i = 1'b1;
      ctrl_wdata_i = d;
      @(negedge clk_i);
      ctrl_wr_i = 1'b0;
   endtask : wr

   // Wait for end of conversion, counting cycles
   task automatic wait_eoc();
      n = 0;
      while (ctrl[sar_adc_pkg::EOC_POS] !== 1'b1 && n < 400) begin
         @(negedge clk_i);
         n++;
      end
   endtask : wait_eoc

   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   // Watchdog
   initial begin
      #(200000);
      bad_count++;
      wrap_up();
   end

   initial begin
      repeat (3) @(negedge clk_i);
      resetn_i = 1'b1;
      chk8(ctrl, sar_adc_pkg::CTRL_RESET);
      chk8(result, 8'h00);
      wr(8'h30);
      @(negedge clk_i);
      chk1(busy, 1'b0);
      wr(8'h10);
      chk1(aen, 1'b1);
      // Conversions across the range, with timing
      for (int i = 0; i < 4; i++) begin
         level = lv[i];
         wr(8'h30);
         chk8(ctrl, 8'h10);
         @(negedge clk_i);
         chk1(busy, 1'b1);
         wait_eoc();
         chk1(n >= CONV - 2 && n <= CONV + CONV / 2, 1'b1);
         chk8(result, lv[i]);
         chk1(irq, 1'b0);
         repeat (CONV) @(negedge clk_i);
         chk1(busy, 1'b0);
         chk8(ctrl, 8'h50);
      end
      // Restart in mid-conversion
      level = 8'h33;
      wr(8'h30);
      repeat (CONV / 2) @(negedge clk_i);
      level = 8'hC4;
      wr(8'h30);
      chk1(ctrl[sar_adc_pkg::EOC_POS], 1'b0);
      wait_eoc();
      chk1(n >= CONV - 2, 1'b1);
      chk8(result, 8'hC4);
      // Interrupt, wake and flag persistence
      wr(8'h90);
      wr(8'hB0);
      wait_eoc();
      @(negedge clk_i);
      chk1(irq, 1'b1);
      chk1(wake, 1'b1);
      wr(8'h90);
      chk1(ctrl[sar_adc_pkg::EOC_POS], 1'b1);
      wr(8'h10);
      @(negedge clk_i);
      chk1(irq, 1'b0);
      wr(8'h90);
      @(negedge clk_i);
      // Stop mode holds converter off, no wake
      stop_mode_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk1(aen, 1'b0);
      chk1(wake, 1'b0);
      wr(8'hB0);
      @(negedge clk_i);
      chk1(busy, 1'b0);
      stop_mode_i = 1'b0;
      wr(8'h00);
      @(negedge clk_i);
      chk1(aen, 1'b0);
      wrap_up();
   end
endmodule : sar_adc_conversion_control_tb
